// ---- rbf_defines.vh ----
/*
 rbf_defines.vh: register indices, field positions, reset values and codes for the
 receive bit framing block.
 assumes: included by rbf_rx_framer.v only; definitions only, no logic.
*/
`ifndef RBF_DEFINES_VH
`define RBF_DEFINES_VH

// register indices; byte address is four times the index
`define RBF_IDX_BIT_FORMAT 8'h58
`define RBF_IDX_END_SYMBOL 8'h59
`define RBF_IDX_START_HIGH 8'h5a
`define RBF_IDX_START_LOW 8'h5b
`define RBF_IDX_SYNC_CTRL 8'h5c
`define RBF_IDX_STATUS 8'h60
`define RBF_IDX_MASK 8'h61
`define RBF_IDX_RX_INFO 8'h62

// rx_bit_format_control fields
`define RBF_BF_STOP_PAR 5
`define RBF_BF_STOP_LEN 4
`define RBF_BF_MSB_FIRST 3
`define RBF_BF_STOP_BIT 2
`define RBF_BF_ODD_PAR 1
`define RBF_BF_WMASK 8'h3e

// sync control fields: pattern length in 7:4, parity enable in bit 0
`define RBF_SC_LEN_HI 7
`define RBF_SC_LEN_LO 4
`define RBF_SC_PAR_EN 0
`define RBF_SC_WMASK 8'hf1

// status and mask bits
`define RBF_ST_DONE 0
`define RBF_ST_FRAME_ERR 1
`define RBF_ST_PARITY_ERR 2
`define RBF_ST_WIDTH 3

// reset values
`define RBF_RST_BIT_FORMAT 8'h00
`define RBF_RST_END_SYMBOL 8'h00
`define RBF_RST_START_HIGH 8'h00
`define RBF_RST_START_LOW 8'h00
`define RBF_RST_SYNC_CTRL 8'h01

// end symbol tuple codes
`define RBF_SYM_NONE 2'h0
`define RBF_SYM_ZERO 2'h1
`define RBF_SYM_ONE 2'h2
`define RBF_SYM_COLL 2'h3

// framer states
`define RBF_S_IDLE 3'h0
`define RBF_S_SOF 3'h1
`define RBF_S_DATA 3'h2
`define RBF_S_PAR 3'h3
`define RBF_S_STOP 3'h4

// bit count and stop bit value
`define RBF_LAST_BIT 3'h7
`define RBF_STOP_VALUE 1'b1

`endif

// ---- rbf_rx_framer.v ----
/*
 rbf_rx_framer.v: receive bit framing for a contactless reader frontend, with a
 classic wishbone register slave, sticky interrupt status and mask.
 assumes: one clock, ref_clk; synchronous active-high reset; demodulator bits arrive
 as single-cycle strobes synchronous to ref_clk; frame_start pulses once per frame.
*/
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rbf_defines.vh"

// Operation
// RULE1: bad parity ends reception when enabled
// RULE2: length stop ends at configured byte count
// RULE3: frame length comes from first byte
// RULE4: bit order selects msb or lsb assembly
// RULE5: stop bit expected, checked, then removed
// RULE6: good stop bit pulses demodulator resync
// RULE7: wrong stop bit flags error, aborts frame
// RULE8: a correct stop bit is one
// RULE9: parity even when cleared, odd when set
// RULE10: end symbol: four two-bit tuples
// RULE11: tuples: none, zero, one, collision
// RULE12: zero tuple closes shorter end symbol
// RULE13: lowest tuple is expected first
// RULE14: low tuple zero disables end symbol
// RULE15: high byte is upper start pattern
// RULE16: low byte is lower start pattern
// RULE17: length field picks valid pattern bits
// RULE18: first enabled stop condition wins
module rbf_rx_framer #(
    parameter ADDR_W = 10,
    parameter NUM_TUPLES = 4
) (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // demodulator side
    input wire frame_start,
    input wire frame_end,
    input wire bit_valid,
    input wire bit_data,
    input wire bit_coll,
    output reg demod_resync,
    // contactless_coprocessor_port
    output reg [7:0] cop_data,
    output reg cop_valid,
    output reg frame_done,
    output reg frame_active,
    // interrupt
    output reg irq
);

    // configuration, status and mask registers
    reg [7:0] bit_format_q;
    reg [7:0] end_symbol_pattern;
    reg [7:0] start_pattern_high_byte;
    reg [7:0] start_pattern_low_byte;
    reg [7:0] sync_ctrl_q;
    reg [`RBF_ST_WIDTH-1:0] status_q;
    reg [`RBF_ST_WIDTH-1:0] mask_q;

    // framer state
    reg [2:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] byte_cnt_q;
    reg [7:0] frame_len_q;
    reg [15:0] sof_q;
    reg [4:0] sof_cnt_q;
    reg [2*NUM_TUPLES-1:0] hist_q;
    reg par_bad_q;

    wire stop_on_bad_parity = bit_format_q[`RBF_BF_STOP_PAR];
    wire stop_on_frame_length = bit_format_q[`RBF_BF_STOP_LEN];
    wire msb_first_receive = bit_format_q[`RBF_BF_MSB_FIRST];
    wire stop_bit_check_enable = bit_format_q[`RBF_BF_STOP_BIT];
    wire odd_parity_select = bit_format_q[`RBF_BF_ODD_PAR];
    wire [3:0] start_pattern_length = sync_ctrl_q[`RBF_SC_LEN_HI:`RBF_SC_LEN_LO];
    wire parity_enable = sync_ctrl_q[`RBF_SC_PAR_EN];

    // bus decode; write lands on the edge where ack is seen high
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire [ADDR_W-3:0] reg_idx = wb_adr_i[ADDR_W-1:2];
    wire bus_wr = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire wr_fmt = bus_wr & (reg_idx == `RBF_IDX_BIT_FORMAT);
    wire wr_eof = bus_wr & (reg_idx == `RBF_IDX_END_SYMBOL);
    wire wr_sh = bus_wr & (reg_idx == `RBF_IDX_START_HIGH);
    wire wr_sl = bus_wr & (reg_idx == `RBF_IDX_START_LOW);
    wire wr_sc = bus_wr & (reg_idx == `RBF_IDX_SYNC_CTRL);
    wire wr_st = bus_wr & (reg_idx == `RBF_IDX_STATUS);
    wire wr_mk = bus_wr & (reg_idx == `RBF_IDX_MASK);

    reg [7:0] rd_val;
    always @* begin
        case (reg_idx)
            `RBF_IDX_BIT_FORMAT: rd_val = bit_format_q;
            `RBF_IDX_END_SYMBOL: rd_val = end_symbol_pattern;
            `RBF_IDX_START_HIGH: rd_val = start_pattern_high_byte;
            `RBF_IDX_START_LOW: rd_val = start_pattern_low_byte;
            `RBF_IDX_SYNC_CTRL: rd_val = sync_ctrl_q;
            `RBF_IDX_STATUS: rd_val = {frame_active, 4'h0, status_q};
            `RBF_IDX_MASK: rd_val = {5'h00, mask_q};
            `RBF_IDX_RX_INFO: rd_val = byte_cnt_q;
            default: rd_val = 8'h00;
        endcase
    end

    // symbol of the incoming bit, same code as the end symbol tuples
    wire [1:0] sym_in = bit_coll ? `RBF_SYM_COLL : (bit_data ? `RBF_SYM_ONE : `RBF_SYM_ZERO); // [RULE11]
    wire [2*NUM_TUPLES-1:0] hist_new = {hist_q[2*NUM_TUPLES-3:0], sym_in};

    // end symbol matching: tuple 0 is the oldest symbol of the window
    wire [NUM_TUPLES-1:0] tup_act;
    wire [NUM_TUPLES-1:0] tup_ok;
    reg [2:0] eof_len;
    integer k;
    always @* begin
        eof_len = 3'h0;
        for (k = 0; k < NUM_TUPLES; k = k + 1) begin
            eof_len = eof_len + {2'b00, tup_act[k]};
        end
    end
    genvar g;
    generate
        for (g = 0; g < NUM_TUPLES; g = g + 1) begin : g_tuple
            // a genvar cannot be part-selected, so its width is fixed here
            localparam [2:0] TUP_POS = g;
            wire [1:0] tup = end_symbol_pattern[2*g+1:2*g]; // [RULE10]
            wire [2:0] age = eof_len - 3'd1 - TUP_POS;
            if (g == 0) begin : g_first
                assign tup_act[g] = (tup != `RBF_SYM_NONE); // [RULE14]
            end else begin : g_rest
                assign tup_act[g] = tup_act[g-1] & (tup != `RBF_SYM_NONE); // [RULE12]
            end
            // the first active tuple is compared with the oldest bit of the window
            assign tup_ok[g] = ~tup_act[g] | (hist_new[2*age +: 2] == tup); // [RULE13]
        end
    endgenerate
    wire eof_hit = tup_act[0] & (&tup_ok); // [RULE14]

    // start pattern: low start_pattern_length bits of {high, low} must match
    wire [15:0] sof_pat = {start_pattern_high_byte, start_pattern_low_byte}; // [RULE15] [RULE16]
    wire [15:0] sof_new = {sof_q[14:0], bit_data};
    wire [15:0] sof_msk = ~(16'hffff << start_pattern_length); // [RULE17]
    wire sof_hit = ((sof_new & sof_msk) == (sof_pat & sof_msk)) &
                   (sof_cnt_q + 5'h01 >= {1'b0, start_pattern_length});

    // byte assembly
    wire [7:0] shift_new = msb_first_receive ? {shift_q[6:0], bit_data}
                                             : {bit_data, shift_q[7:1]}; // [RULE4]
    wire par_exp = (^shift_q) ^ odd_parity_select; // [RULE9]
    wire par_bad = (bit_data != par_exp);
    wire [7:0] cnt_next = byte_cnt_q + 8'h01;
    // the first byte sets the length, so it is compared against itself when it lands
    wire [7:0] len_eff = (byte_cnt_q == 8'h00) ? shift_q : frame_len_q; // [RULE3]
    wire len_hit = stop_on_frame_length & (cnt_next >= len_eff); // [RULE2]

    // status events
    reg ev_done;
    reg ev_ferr;
    reg ev_perr;
    wire [`RBF_ST_WIDTH-1:0] ev_vec = {ev_perr, ev_ferr, ev_done};

    always @(posedge ref_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            bit_format_q <= `RBF_RST_BIT_FORMAT;
            end_symbol_pattern <= `RBF_RST_END_SYMBOL;
            start_pattern_high_byte <= `RBF_RST_START_HIGH;
            start_pattern_low_byte <= `RBF_RST_START_LOW;
            sync_ctrl_q <= `RBF_RST_SYNC_CTRL;
            status_q <= {`RBF_ST_WIDTH{1'b0}};
            mask_q <= {`RBF_ST_WIDTH{1'b0}};
            irq <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o) begin
                wb_dat_o <= {24'h00_0000, rd_val};
            end
            if (wr_fmt) begin
                bit_format_q <= wb_dat_i[7:0] & `RBF_BF_WMASK;
            end
            if (wr_eof) begin
                end_symbol_pattern <= wb_dat_i[7:0];
            end
            if (wr_sh) begin
                start_pattern_high_byte <= wb_dat_i[7:0];
            end
            if (wr_sl) begin
                start_pattern_low_byte <= wb_dat_i[7:0];
            end
            if (wr_sc) begin
                sync_ctrl_q <= wb_dat_i[7:0] & `RBF_SC_WMASK;
            end
            if (wr_mk) begin
                mask_q <= wb_dat_i[`RBF_ST_WIDTH-1:0];
            end
            // a new event beats a write-one clear in the same cycle
            status_q <= (status_q & ~(wr_st ? wb_dat_i[`RBF_ST_WIDTH-1:0]
                                            : {`RBF_ST_WIDTH{1'b0}})) | ev_vec;
            irq <= |(((status_q & ~(wr_st ? wb_dat_i[`RBF_ST_WIDTH-1:0]
                                          : {`RBF_ST_WIDTH{1'b0}})) | ev_vec) & mask_q);
        end
    end

    // framer
    always @(posedge ref_clk) begin
        if (reset) begin
            state_q <= `RBF_S_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            byte_cnt_q <= 8'h00;
            frame_len_q <= 8'h00;
            sof_q <= 16'h0000;
            sof_cnt_q <= 5'h00;
            hist_q <= {2*NUM_TUPLES{1'b0}};
            par_bad_q <= 1'b0;
            cop_data <= 8'h00;
            cop_valid <= 1'b0;
            frame_done <= 1'b0;
            frame_active <= 1'b0;
            demod_resync <= 1'b0;
            ev_done <= 1'b0;
            ev_ferr <= 1'b0;
            ev_perr <= 1'b0;
        end else begin
            cop_valid <= 1'b0;
            frame_done <= 1'b0;
            demod_resync <= 1'b0;
            ev_done <= 1'b0;
            ev_ferr <= 1'b0;
            ev_perr <= 1'b0;
            case (state_q)
                `RBF_S_IDLE: begin
                    if (frame_start) begin
                        byte_cnt_q <= 8'h00;
                        frame_len_q <= 8'h00;
                        bit_cnt_q <= 3'h0;
                        sof_q <= 16'h0000;
                        sof_cnt_q <= 5'h00;
                        hist_q <= {2*NUM_TUPLES{1'b0}};
                        frame_active <= 1'b1;
                        // zero length means no start pattern to hunt for
                        state_q <= (start_pattern_length == 4'h0) ? `RBF_S_DATA
                                                                  : `RBF_S_SOF; // [RULE17]
                    end
                end
                `RBF_S_SOF: begin
                    if (frame_end) begin
                        state_q <= `RBF_S_IDLE;
                        frame_active <= 1'b0;
                        frame_done <= 1'b1;
                        ev_done <= 1'b1;
                    end else if (bit_valid) begin
                        sof_q <= sof_new;
                        if (sof_cnt_q != 5'h1f) begin
                            sof_cnt_q <= sof_cnt_q + 5'h01;
                        end
                        if (sof_hit) begin
                            state_q <= `RBF_S_DATA; // [RULE15] [RULE16]
                        end
                    end
                end
                `RBF_S_DATA, `RBF_S_PAR, `RBF_S_STOP: begin
                    if (frame_end) begin
                        // demodulator ends the frame; partial bits are dropped
                        state_q <= `RBF_S_IDLE;
                        frame_active <= 1'b0;
                        frame_done <= 1'b1;
                        ev_done <= 1'b1;
                    end else if (bit_valid) begin
                        hist_q <= hist_new;
                        if (eof_hit) begin
                            // checked before the bit is used, so it wins a tie
                            state_q <= `RBF_S_IDLE; // [RULE18]
                            frame_active <= 1'b0;
                            frame_done <= 1'b1;
                            ev_done <= 1'b1;
                        end else if (state_q == `RBF_S_DATA) begin
                            shift_q <= shift_new;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == `RBF_LAST_BIT) begin
                                if (parity_enable) begin
                                    state_q <= `RBF_S_PAR;
                                end else begin
                                    cop_data <= shift_new;
                                    cop_valid <= 1'b1;
                                    byte_cnt_q <= cnt_next;
                                    if (byte_cnt_q == 8'h00) begin
                                        frame_len_q <= shift_new; // [RULE3]
                                    end
                                    if (stop_on_frame_length &
                                        (cnt_next >= ((byte_cnt_q == 8'h00) ? shift_new
                                                                            : frame_len_q))) begin
                                        state_q <= `RBF_S_IDLE; // [RULE2] [RULE18]
                                        frame_active <= 1'b0;
                                        frame_done <= 1'b1;
                                        ev_done <= 1'b1;
                                    end else if (stop_bit_check_enable) begin
                                        state_q <= `RBF_S_STOP; // [RULE5]
                                    end
                                end
                            end
                        end else if (state_q == `RBF_S_PAR) begin
                            // parity bit is consumed, the byte still goes out
                            cop_data <= shift_q;
                            cop_valid <= 1'b1;
                            byte_cnt_q <= cnt_next;
                            par_bad_q <= par_bad;
                            ev_perr <= par_bad;
                            if (byte_cnt_q == 8'h00) begin
                                frame_len_q <= shift_q; // [RULE3]
                            end
                            if ((stop_on_bad_parity & par_bad) | len_hit) begin
                                state_q <= `RBF_S_IDLE; // [RULE1] [RULE2] [RULE18]
                                frame_active <= 1'b0;
                                frame_done <= 1'b1;
                                ev_done <= 1'b1;
                            end else if (stop_bit_check_enable) begin
                                state_q <= `RBF_S_STOP; // [RULE5]
                            end else begin
                                state_q <= `RBF_S_DATA;
                            end
                        end else begin
                            // stop bit never reaches the coprocessor port
                            if (bit_data == `RBF_STOP_VALUE && !bit_coll) begin // [RULE8]
                                demod_resync <= 1'b1; // [RULE6]
                                state_q <= `RBF_S_DATA; // [RULE5]
                            end else begin
                                state_q <= `RBF_S_IDLE; // [RULE7]
                                frame_active <= 1'b0;
                                frame_done <= 1'b1;
                                ev_ferr <= 1'b1;
                                ev_done <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= `RBF_S_IDLE;
                    frame_active <= 1'b0;
                end
            endcase
        end
    end

endmodule // rbf_rx_framer

// ---- rbf_rx_framer_chk.sv ----
/* rbf_rx_framer_chk.sv: port-level assertions for the receive framer.
   assumes: bound to rbf_rx_framer from the testbench top file; one clock. */
`timescale 1ns/1ps
module rbf_rx_framer_chk (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // link
    input wire frame_start,
    input wire bit_valid,
    input wire bit_data,
    input wire bit_coll,
    input wire demod_resync,
    input wire cop_valid,
    input wire frame_done,
    input wire frame_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // a zero or a collision can never be a good stop bit
    sequence s_bad_bit;
        bit_valid && (bit_coll || !bit_data);
    endsequence
    sequence s_start;
        frame_start && !frame_active;
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack wider than one cycle");
    a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_resync_cause: assert property (demod_resync |-> $past(bit_valid && bit_data && !bit_coll))
        else $error("resync without a good stop bit");
    a_no_resync: assert property (s_bad_bit |=> !demod_resync)
        else $error("resync after a zero or collision bit");
    a_start_act: assert property (s_start |=> frame_active)
        else $error("frame not active after start");
    a_cop_gap: assert property (cop_valid |=> !cop_valid [*7])
        else $error("bytes closer than eight bits");
    a_cop_frame: assert property (cop_valid |-> $past(frame_active))
        else $error("byte delivered outside a frame");
    a_done_end: assert property (frame_done |-> !frame_active && $past(frame_active))
        else $error("done pulse without frame closing");
endmodule // rbf_rx_framer_chk

// ---- rbf_demod_model.sv ----
/* rbf_demod_model.sv: behavioural demodulator handing decoded bits to the framer.
   assumes: its tasks are called by the bench; outputs change just after a rising edge. */
`timescale 1ns/1ps
module rbf_demod_model (
    // clock
    input wire ref_clk,
    // decoded bit stream
    output reg frame_start,
    output reg frame_end,
    output reg bit_valid,
    output reg bit_data,
    output reg bit_coll
);
    initial begin
        frame_start = 1'b0;
        frame_end = 1'b0;
        bit_valid = 1'b0;
        bit_data = 1'b0;
        bit_coll = 1'b0;
    end
    task start;
        begin
            @(posedge ref_clk);
            frame_start <= 1'b1;
            @(posedge ref_clk);
            frame_start <= 1'b0;
        end
    endtask
    // back-to-back calls keep the strobe high, one bit per cycle
    task sbit(input d, input c);
        begin
            @(posedge ref_clk);
            bit_valid <= 1'b1;
            bit_data <= d;
            bit_coll <= c;
        end
    endtask
    // a released data line shows the inverse, so a stale bit is never reused
    task idle;
        begin
            @(posedge ref_clk);
            bit_valid <= 1'b0;
            bit_coll <= 1'b0;
            bit_data <= ~bit_data;
        end
    endtask
    task fin;
        begin
            idle;
            frame_end <= 1'b1;
            @(posedge ref_clk);
            frame_end <= 1'b0;
        end
    endtask
endmodule // rbf_demod_model

// ---- tb_rbf_rx_framer.sv ----
/* tb_rbf_rx_framer.sv: self-checking bench for the receive framer.
   assumes: rbf_demod_model drives the bit side; the checker is bound at the foot. */
`timescale 1ns/1ps
module tb_rbf_rx_framer;
    reg ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i;
    reg [9:0] wb_adr_i;
    reg [3:0] wb_sel_i;
    reg [31:0] wb_dat_i;
    wire [31:0] wb_dat_o;
    wire [7:0] cop_data;
    wire wb_ack_o, frame_start, frame_end, bit_valid, bit_data, bit_coll;
    wire demod_resync, cop_valid, frame_done, frame_active, irq;
    integer err_total, n_tests, n_res, k, j, len, r0, seed;
    reg [7:0] bf, v0, v1, q;
    reg [7:0] got [$];
    rbf_rx_framer uut (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .frame_start, .frame_end, .bit_valid,
        .bit_data, .bit_coll, .demod_resync, .cop_data, .cop_valid, .frame_done,
        .frame_active, .irq);
    rbf_demod_model dm (.ref_clk, .frame_start, .frame_end, .bit_valid, .bit_data, .bit_coll);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // sampled at the edge, before that edge's registered updates land
    always @(posedge ref_clk) begin
        if (cop_valid === 1'b1) got.push_back(cop_data);
        if (demod_resync === 1'b1) n_res = n_res + 1;
    end
    task chk(input [31:0] a, input [31:0] e, input string m);
        begin
            n_tests = n_tests + 1;
            if (a !== e) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, e);
            end
        end
    endtask
    task wb(input we, input [7:0] idx, input [7:0] d);
        integer n;
        begin
            @(posedge ref_clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= {idx, 2'b00};
            wb_dat_i <= {24'h00_0000, d};
            n = 0;
            do begin
                @(posedge ref_clk);
                n = n + 1;
            end while (wb_ack_o !== 1'b1 && n < 20);
            if (wb_ack_o !== 1'b1) chk(0, 1, "bus timeout");
            q = wb_dat_o[7:0];
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    task rdc(input [7:0] idx, input [7:0] m, input [7:0] e);
        begin
            wb(1'b0, idx, 8'h00);
            chk(q & m, e, "register read");
        end
    endtask
    task fmt(input [7:0] f);
        begin
            wb(1'b1, 8'h58, f);
            bf = f;
        end
    endtask
    function par(input [7:0] v);
        par = ^v ^ bf[1];
    endfunction
    // st: 0 no stop bit, 2 good stop bit, 3 wrong stop bit
    task sbyte(input [7:0] v, input pbad, input [1:0] st);
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                if ($urandom % 4 == 0) dm.idle();
                dm.sbit(bf[3] ? v[7 - i] : v[i], 1'b0);
            end
            dm.sbit(par(v) ^ pbad, 1'b0);
            if (st[1]) dm.sbit(~st[0], 1'b0);
        end
    endtask
    task settle;
        begin
            dm.idle();
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (50000) @(posedge ref_clk);
        err_total = err_total + 1;
        summarize;
    end
    initial begin
        err_total = 0;
        n_tests = 0;
        n_res = 0;
        bf = 8'h00;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 0;
        wb_sel_i = 4'h1;
        reset = 1'b1;
        seed = $urandom(32'hc117);
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        for (k = 0; k < 5; k = k + 1) rdc(8'h58 + k, 8'hff, k == 4);
        wb(1'b1, 8'h70, 8'hff);
        rdc(8'h70, 8'hff, 8'h00);
        fmt(8'hff);
        rdc(8'h58, 8'hff, 8'h3e);
        $display("test registers done");
        for (k = 0; k < 8; k = k + 1) begin
            fmt($urandom & 8'h0a);
            v0 = $urandom;
            v1 = $urandom;
            got.delete();
            dm.start();
            sbyte(v0, 1'b0, 2'd0);
            sbyte(v1, 1'b0, 2'd0);
            dm.fin();
            settle;
            chk(got.size(), 2, "byte count");
            chk({got[0], got[1]}, {v0, v1}, "bytes");
        end
        $display("test order and parity done");
        fmt(8'h20);
        dm.start();
        sbyte(v0, 1'b1, 2'd0);
        settle;
        chk(frame_active, 0, "parity stop");
        fmt(8'h00);
        wb(1'b1, 8'h60, 8'h07);
        dm.start();
        sbyte(v0, 1'b1, 2'd0);
        settle;
        chk(frame_active, 1, "parity no stop");
        rdc(8'h60, 8'h04, 8'h04);
        dm.fin();
        $display("test parity stop done");
        fmt(8'h04);
        got.delete();
        r0 = n_res;
        dm.start();
        sbyte(v0, 1'b0, 2'd2);
        sbyte(v1, 1'b0, 2'd2);
        settle;
        chk(n_res - r0, 2, "resync count");
        chk({got[0], got[1]}, {v0, v1}, "stop removed");
        sbyte(v1, 1'b0, 2'd3);
        settle;
        chk(frame_active, 0, "wrong stop aborts");
        rdc(8'h60, 8'h02, 8'h02);
        $display("test stop bit done");
        fmt(8'h10);
        got.delete();
        len = 3 + $urandom % 3;
        dm.start();
        sbyte(len, 1'b0, 2'd0);
        for (j = 1; j < len; j = j + 1) begin
            settle;
            chk(frame_active, 1, "length early");
            sbyte($urandom, 1'b0, 2'd0);
        end
        settle;
        chk(frame_active, 0, "length stop");
        chk(got.size(), len, "length bytes");
        fmt(8'h30);
        dm.start();
        sbyte(8'h09, 1'b1, 2'd0);
        settle;
        chk(frame_active, 0, "first stop wins");
        $display("test length done");
        fmt(8'h00);
        wb(1'b1, 8'h59, 8'h06);
        dm.start();
        dm.sbit(1'b0, 1'b0);
        dm.sbit(1'b1, 1'b0);
        settle;
        chk(frame_active, 1, "reversed symbol");
        dm.sbit(1'b0, 1'b0);
        settle;
        chk(frame_active, 0, "one zero symbol");
        wb(1'b1, 8'h59, 8'h1d);
        dm.start();
        dm.sbit(1'b0, 1'b0);
        dm.sbit(1'b1, 1'b1);
        dm.sbit(1'b0, 1'b0);
        settle;
        chk(frame_active, 0, "three bit symbol");
        wb(1'b1, 8'h59, 8'he8);
        got.delete();
        dm.start();
        sbyte(8'hff, 1'b0, 2'd0);
        settle;
        chk({frame_active, got[0]}, 9'h1ff, "symbol disabled");
        dm.fin();
        wb(1'b1, 8'h59, 8'h00);
        $display("test end symbol done");
        wb(1'b1, 8'h5a, 8'ha5);
        wb(1'b1, 8'h5b, 8'h3c);
        wb(1'b1, 8'h5c, 8'hc1);
        for (k = 0; k < 2; k = k + 1) begin
            got.delete();
            dm.start();
            for (j = 11; j >= 0; j = j - 1) dm.sbit((16'ha53c >> j) ^ (k && j == 11), 1'b0);
            sbyte(8'h00, 1'b0, 2'd0);
            settle;
            chk(got.size(), 1 - k, "start pattern");
            dm.fin();
        end
        wb(1'b1, 8'h5c, 8'h01);
        $display("test start pattern done");
        wb(1'b1, 8'h61, 8'h00);
        settle;
        chk(irq, 0, "irq masked");
        wb(1'b1, 8'h61, 8'h07);
        settle;
        chk(irq, 1, "irq raised");
        wb(1'b1, 8'h60, 8'h07);
        settle;
        chk(irq, 0, "irq cleared");
        rdc(8'h60, 8'h07, 8'h00);
        $display("test interrupt done");
        summarize;
    end
endmodule // tb_rbf_rx_framer
bind rbf_rx_framer rbf_rx_framer_chk u_chk (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .frame_start, .bit_valid, .bit_data, .bit_coll, .demod_resync,
    .cop_valid, .frame_done, .frame_active);
